//--- hw/tsf_pkg.sv
/*
 * Constants shared by the timer status flag block: register byte offsets,
 * field positions, reset values and mode encodings.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package tsf_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_SLAVE     = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] OFF_STATUS    = 8'h10;
    localparam logic [7:0] OFF_EVGEN     = 8'h14;
    localparam logic [7:0] OFF_CH_CFG    = 8'h20;
    localparam logic [7:0] OFF_CH_VALUE0 = 8'h34;
    localparam logic [7:0] OFF_CH_STEP   = 8'h04;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_UPDATE_INHIBIT = 1;
    localparam int BIT_UPDATE_SOURCE  = 2;
    localparam int BIT_UPDATE_FLAG    = 0;
    localparam int BIT_CH_EVENT_LO    = 1;
    localparam int BIT_TRIGGER_FLAG   = 6;
    localparam int BIT_CH_OVERRUN_LO  = 9;
    localparam int BIT_GEN_TRIGGER    = 6;
    localparam int BIT_CFG_POLARITY   = 4;
    localparam int SLAVE_MODE_LSB     = 0;

    // Status bits that exist; reserved positions read zero.
    localparam logic [31:0] STATUS_IMPL  = 32'h0000_1e5f;
    localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;
    localparam logic [15:0] VALUE_RESET  = 16'h0000;

    // ****************************************************************
    // Slave modes and centre-aligned selections
    // ****************************************************************
    localparam logic [1:0] SLAVE_OFF   = 2'h0;
    localparam logic [1:0] SLAVE_RESET = 2'h1;
    localparam logic [1:0] SLAVE_GATED = 2'h2;
    localparam logic [1:0] SLAVE_TRIG  = 2'h3;

    localparam logic [1:0] ALIGN_EDGE  = 2'h0;
    localparam logic [1:0] ALIGN_DOWN  = 2'h1;
    localparam logic [1:0] ALIGN_UP    = 2'h2;
    localparam logic [1:0] ALIGN_BOTH  = 2'h3;

endpackage

//--- hw/tsf_status_flags.sv
/*
 * Timer status flags: update, trigger, per-channel event and overrun
 * flags, the conditions that set them, the channel value registers and
 * an Avalon-MM slave with waitrequest.
 * Assumes the counter, prescaler and direction logic sit outside on the
 * same clock; trigger and channel inputs are asynchronous pins.
 */
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tsf_status_flags #(
    parameter int CHANNELS  = 4,
    parameter int CNT_WIDTH = 16
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic [CNT_WIDTH-1:0] counter_value,
    input  wire logic                 counter_wrap,
    input  wire logic                 count_down,
    input  wire logic [1:0]           center_align_select,
    input  wire logic                 slave_trigger_input,
    input  wire logic [CHANNELS-1:0]  ch_input_signal,
    output logic                      counter_reinit,
    output logic                      gate_open,
    output logic                      irq
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    initial begin
        if (CHANNELS != 4) begin
            $error("tsf_status_flags supports exactly four channels");
        end
        if (CNT_WIDTH < 1 || CNT_WIDTH > 32) begin
            $error("tsf_status_flags counter width must be 1 to 32");
        end
    end

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // Every access waits one cycle so read data come from a flip-flop.
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    wire         bus_req  = avs_read | avs_write;
    wire         wr_acc   = avs_write & ack_q;
    wire         rd_acc   = avs_read & ack_q;
    wire  [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    assign ack_d           = bus_req & ~ack_q;
    assign avs_waitrequest = bus_req & ~ack_q;
    assign avs_readdata    = rdata_q;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire sel_control = (avs_address == tsf_pkg::OFF_CONTROL);
    wire sel_slave   = (avs_address == tsf_pkg::OFF_SLAVE);
    wire sel_mask    = (avs_address == tsf_pkg::OFF_IRQ_MASK);
    wire sel_status  = (avs_address == tsf_pkg::OFF_STATUS);
    wire sel_evgen   = (avs_address == tsf_pkg::OFF_EVGEN);
    wire sel_cfg     = (avs_address == tsf_pkg::OFF_CH_CFG);

    logic [CHANNELS-1:0] sel_value;

    // ****************************************************************
    // Software registers
    // ****************************************************************
    logic [31:0] control_q;
    logic [31:0] control_d;
    logic [31:0] slave_q;
    logic [31:0] slave_d;
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [31:0] status_q;
    logic [31:0] status_d;

    wire [31:0] wr_merge_control = (control_q & ~be_mask) | (avs_writedata & be_mask);
    wire [31:0] wr_merge_slave   = (slave_q & ~be_mask) | (avs_writedata & be_mask);
    wire [31:0] wr_merge_mask    = (mask_q & ~be_mask) | (avs_writedata & be_mask);
    wire [31:0] wr_merge_cfg     = (cfg_q & ~be_mask) | (avs_writedata & be_mask);

    assign control_d = (wr_acc & sel_control) ? wr_merge_control : control_q;
    assign slave_d   = (wr_acc & sel_slave) ? wr_merge_slave : slave_q;
    assign mask_d    = (wr_acc & sel_mask) ? (wr_merge_mask & tsf_pkg::STATUS_IMPL) : mask_q;
    assign cfg_d     = (wr_acc & sel_cfg) ? wr_merge_cfg : cfg_q;

    wire       update_inhibit       = control_q[tsf_pkg::BIT_UPDATE_INHIBIT];
    wire       update_source_select = control_q[tsf_pkg::BIT_UPDATE_SOURCE];
    wire [1:0] slave_mode           = slave_q[tsf_pkg::SLAVE_MODE_LSB +: 2];
    wire [CHANNELS-1:0] ch_is_input = cfg_q[CHANNELS-1:0];
    wire [CHANNELS-1:0] ch_falling  = cfg_q[tsf_pkg::BIT_CFG_POLARITY +: CHANNELS];

    // Event generation bits are pulses; the register itself stores nothing.
    wire evgen_acc              = wr_acc & sel_evgen;
    wire software_update_request = evgen_acc & avs_writedata[tsf_pkg::BIT_UPDATE_FLAG]
                                   & avs_byteenable[0];
    wire gen_trigger            = evgen_acc & avs_writedata[tsf_pkg::BIT_GEN_TRIGGER]
                                   & avs_byteenable[0];
    wire [CHANNELS-1:0] gen_ch  = {CHANNELS{evgen_acc & avs_byteenable[0]}}
                                   & avs_writedata[tsf_pkg::BIT_CH_EVENT_LO +: CHANNELS];

    // Bits that a status write clears: zero written in an enabled lane.
    wire status_wr = wr_acc & sel_status;
    wire [31:0] status_clr = {32{status_wr}} & be_mask & ~avs_writedata;

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic                trig_s1_q;
    logic                trig_s2_q;
    logic                trig_prev_q;
    logic [CHANNELS-1:0] ch_s1_q;
    logic [CHANNELS-1:0] ch_s2_q;
    logic [CHANNELS-1:0] ch_prev_q;
    logic [CNT_WIDTH-1:0] cnt_prev_q;

    wire trig_rise = trig_s2_q & ~trig_prev_q;
    wire trig_fall = ~trig_s2_q & trig_prev_q;
    wire [CHANNELS-1:0] ch_rise = ch_s2_q & ~ch_prev_q;
    wire [CHANNELS-1:0] ch_fall = ~ch_s2_q & ch_prev_q;
    wire [CHANNELS-1:0] ch_edge = (ch_rise & ~ch_falling) | (ch_fall & ch_falling);
    wire cnt_moved = (counter_value != cnt_prev_q);

    // ****************************************************************
    // Trigger and update events
    // ****************************************************************
    wire slave_on    = (slave_mode != tsf_pkg::SLAVE_OFF);
    wire mode_gated  = (slave_mode == tsf_pkg::SLAVE_GATED);
    wire mode_reset  = (slave_mode == tsf_pkg::SLAVE_RESET);
    wire trig_edge_event  = slave_on & ~mode_gated & trig_rise;
    wire trig_gate_event  = mode_gated & (trig_rise | trig_fall);
    wire trigger_reinit   = mode_reset & trig_rise;
    wire set_trigger      = trig_edge_event | trig_gate_event | gen_trigger;
    wire update_allowed   = ~update_source_select & ~update_inhibit;
    wire set_update = (counter_wrap & ~update_inhibit)
                    | (software_update_request & update_allowed)
                    | (trigger_reinit & update_allowed);

    assign gate_open      = mode_gated & trig_s2_q;
    assign counter_reinit = software_update_request | trigger_reinit;

    // In centre-aligned counting a match only counts in the chosen direction.
    wire match_dir_ok = (center_align_select == tsf_pkg::ALIGN_EDGE)
                      | (center_align_select == tsf_pkg::ALIGN_BOTH)
                      | ((center_align_select == tsf_pkg::ALIGN_DOWN) & count_down)
                      | ((center_align_select == tsf_pkg::ALIGN_UP) & ~count_down);

    // ****************************************************************
    // Channels
    // ****************************************************************
    logic [CNT_WIDTH-1:0] ch_value_q [CHANNELS];
    logic [CHANNELS-1:0]  ch_event_q;
    logic [CHANNELS-1:0]  ch_overrun_q;
    logic [CHANNELS-1:0]  ch_event_d;
    logic [CHANNELS-1:0]  ch_overrun_d;
    logic [CHANNELS-1:0]  ch_capture;
    logic [CHANNELS-1:0]  ch_match;
    logic [31:0]          value_rd [CHANNELS];

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
            localparam int EV = tsf_pkg::BIT_CH_EVENT_LO + gi;
            localparam int OV = tsf_pkg::BIT_CH_OVERRUN_LO + gi;
            localparam logic [7:0] OFFS = 8'(tsf_pkg::OFF_CH_VALUE0
                                             + 8'(gi) * tsf_pkg::OFF_CH_STEP);
            wire in_mode  = ch_is_input[gi];
            wire rd_clear = rd_acc & sel_value[gi] & in_mode;
            wire set_ev;
            wire set_ov;

            assign sel_value[gi]  = (avs_address == OFFS);
            assign ch_capture[gi] = in_mode & (ch_edge[gi] | gen_ch[gi]);
            assign ch_match[gi]   = ~in_mode & ((cnt_moved & match_dir_ok
                                    & (counter_value == ch_value_q[gi]))
                                    | gen_ch[gi]);
            assign set_ev = ch_capture[gi] | ch_match[gi];
            assign set_ov = ch_capture[gi] & ch_event_q[gi];
            assign ch_event_d[gi]   = set_ev
                                    | (ch_event_q[gi] & ~status_clr[EV] & ~rd_clear);
            assign ch_overrun_d[gi] = set_ov | (ch_overrun_q[gi] & ~status_clr[OV]);
            assign value_rd[gi] = 32'(ch_value_q[gi]);

            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    ch_value_q[gi] <= tsf_pkg::VALUE_RESET[CNT_WIDTH-1:0];
                end else if (ch_capture[gi]) begin
                    ch_value_q[gi] <= counter_value;
                end else if (wr_acc & sel_value[gi] & ~in_mode) begin
                    // A captured value is read-only; writes only load a compare value.
                    ch_value_q[gi] <= avs_writedata[CNT_WIDTH-1:0];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Status register
    // ****************************************************************
    logic update_flag_d;
    logic trigger_flag_d;

    assign update_flag_d  = set_update
                          | (status_q[tsf_pkg::BIT_UPDATE_FLAG]
                             & ~status_clr[tsf_pkg::BIT_UPDATE_FLAG]);
    assign trigger_flag_d = set_trigger
                          | (status_q[tsf_pkg::BIT_TRIGGER_FLAG]
                             & ~status_clr[tsf_pkg::BIT_TRIGGER_FLAG]);

    always_comb begin
        status_d = tsf_pkg::RESET_ZERO;
        status_d[tsf_pkg::BIT_UPDATE_FLAG]                  = update_flag_d;
        status_d[tsf_pkg::BIT_CH_EVENT_LO +: CHANNELS]      = ch_event_d;
        status_d[tsf_pkg::BIT_TRIGGER_FLAG]                 = trigger_flag_d;
        status_d[tsf_pkg::BIT_CH_OVERRUN_LO +: CHANNELS]    = ch_overrun_d;
    end

    assign ch_event_q   = status_q[tsf_pkg::BIT_CH_EVENT_LO +: CHANNELS];
    assign ch_overrun_q = status_q[tsf_pkg::BIT_CH_OVERRUN_LO +: CHANNELS];
    assign irq = |(status_q & mask_q);

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always_comb begin
        rdata_d = tsf_pkg::RESET_ZERO;
        if (sel_control) begin
            rdata_d = control_q;
        end else if (sel_slave) begin
            rdata_d = slave_q;
        end else if (sel_mask) begin
            rdata_d = mask_q;
        end else if (sel_status) begin
            rdata_d = status_q & tsf_pkg::STATUS_IMPL;
        end else if (sel_cfg) begin
            rdata_d = cfg_q;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (sel_value[i]) begin
                    rdata_d = value_rd[i];
                end
            end
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_q     <= 1'b0;
            rdata_q   <= tsf_pkg::RESET_ZERO;
            control_q <= tsf_pkg::RESET_ZERO;
            slave_q   <= tsf_pkg::RESET_ZERO;
            mask_q    <= tsf_pkg::RESET_ZERO;
            cfg_q     <= tsf_pkg::RESET_ZERO;
            status_q  <= tsf_pkg::RESET_ZERO;
        end else begin
            ack_q     <= ack_d;
            rdata_q   <= (avs_read & ~ack_q) ? rdata_d : rdata_q;
            control_q <= control_d;
            slave_q   <= slave_d;
            mask_q    <= mask_d;
            cfg_q     <= cfg_d;
            status_q  <= status_d;
        end
    end

    // The first stage feeds only the second; edges are taken after it.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            trig_s1_q   <= 1'b0;
            trig_s2_q   <= 1'b0;
            trig_prev_q <= 1'b0;
            ch_s1_q     <= '0;
            ch_s2_q     <= '0;
            ch_prev_q   <= '0;
            cnt_prev_q  <= '0;
        end else begin
            trig_s1_q   <= slave_trigger_input;
            trig_s2_q   <= trig_s1_q;
            trig_prev_q <= trig_s2_q;
            ch_s1_q     <= ch_input_signal;
            ch_s2_q     <= ch_s1_q;
            ch_prev_q   <= ch_s2_q;
            cnt_prev_q  <= counter_value;
        end
    end

endmodule

`default_nettype wire

//--- bench/tsf_status_flags_properties.sv
/*
 * Concurrent checks on the ports of the timer status flag block.
 * Assumes one clock, clk, and a bench master that holds each request.
 */
`timescale 1ns/1ps
`default_nettype none
module tsf_status_flags_properties #(
    parameter int CHANNELS  = 4,
    parameter int CNT_WIDTH = 16
) (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic [7:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic [3:0]           avs_byteenable,
    input wire logic [31:0]          avs_readdata,
    input wire logic                 avs_waitrequest,
    input wire logic [CNT_WIDTH-1:0] counter_value,
    input wire logic                 counter_wrap,
    input wire logic                 count_down,
    input wire logic [1:0]           center_align_select,
    input wire logic                 slave_trigger_input,
    input wire logic [CHANNELS-1:0]  ch_input_signal,
    input wire logic                 counter_reinit,
    input wire logic                 gate_open,
    input wire logic                 irq
);
    // ****************************************************************
    // Bus and flag relations
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    wire logic req = avs_read | avs_write;

    sequence taken_s;
        req && !avs_waitrequest;
    endsequence
    sequence ug_write_s;
        taken_s ##0 avs_write && avs_address == tsf_pkg::OFF_EVGEN && avs_writedata[0];
    endsequence

    wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
        else $error("new request not held off");
    one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    access_len_a: assert property (taken_s |=> !req || avs_waitrequest)
        else $error("access shorter than two cycles");
    reset_clear_a: assert property ($rose(reset_n) |-> !irq && avs_readdata == 32'h0)
        else $error("outputs not cleared by reset");
    reserved_zero_a: assert property (taken_s ##0 avs_read && avs_address == tsf_pkg::OFF_STATUS
        |-> (avs_readdata & ~tsf_pkg::STATUS_IMPL) == 32'h0)
        else $error("reserved status bits not zero");
    evgen_zero_a: assert property (taken_s ##0 avs_read && avs_address == tsf_pkg::OFF_EVGEN
        |-> avs_readdata == 32'h0)
        else $error("event generation read not zero");
    rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    ug_reinit_a: assert property (ug_write_s |-> ##[0:2] counter_reinit)
        else $error("software update did not reinitialise");
    reinit_pulse_a: assert property (counter_reinit |=> !counter_reinit)
        else $error("reinit longer than one cycle");
    gate_sync_a: assert property (gate_open |-> $past(slave_trigger_input, 2))
        else $error("gate open without a synchronised trigger");
    irq_hold_a: assert property ($fell(irq) |-> $past(avs_write || avs_read))
        else $error("interrupt dropped without a bus access");
endmodule
`default_nettype wire

//--- bench/tsf_status_flags_bench.sv
/*
 * Self-checking bench for the timer status flag block.
 * Assumes the block answers every bus access after one wait state.
 */
`timescale 1ns/1ps
`default_nettype none
module tsf_status_flags_bench;
    typedef struct {logic [31:0] ctrl; logic [31:0] slave; int act; logic [31:0] exp;} tsf_row_s;
    logic        clk, reset_n, avs_read, avs_write, counter_wrap, count_down;
    logic        slave_trigger_input, avs_waitrequest, counter_reinit, gate_open, irq;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable, ch_input_signal;
    logic [15:0] counter_value;
    logic [1:0]  center_align_select;
    int          n_errors, n_compared, cycles;
    tsf_row_s    rows[11];

    tsf_status_flags DUT (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .counter_value(counter_value),
        .counter_wrap(counter_wrap), .count_down(count_down),
        .center_align_select(center_align_select), .slave_trigger_input(slave_trigger_input),
        .ch_input_signal(ch_input_signal), .counter_reinit(counter_reinit),
        .gate_open(gate_open), .irq(irq));

    // ****************************************************************
    // Clock, watchdog and helpers
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // The ceiling is far above the few hundred cycles the tests need.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    endtask
    // One idle cycle precedes each request, so no strobe is driven twice in one step.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        #1;
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk_word(rd, exp);
    endtask
    task automatic toggle(input logic trig, input logic lvl);
        if (trig) slave_trigger_input <= lvl;
        else ch_input_signal[0] <= lvl;
        repeat (4) @(posedge clk);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {avs_read, avs_write, counter_wrap, count_down, slave_trigger_input} = 5'h00;
        {avs_address, avs_writedata, counter_value, center_align_select} = '0;
        {n_errors, n_compared, cycles} = '0;
        avs_byteenable = 4'hf;
        ch_input_signal = 4'h0;
        reset_n = 1'b0;
        rows = '{'{32'h0, 32'h0, 0, 32'h1}, '{32'h2, 32'h0, 0, 32'h0}, '{32'h4, 32'h0, 0, 32'h1},
            '{32'h0, 32'h0, 1, 32'h1}, '{32'h4, 32'h0, 1, 32'h0}, '{32'h2, 32'h0, 1, 32'h0},
            '{32'h0, 32'h1, 2, 32'h41}, '{32'h4, 32'h1, 2, 32'h40}, '{32'h2, 32'h3, 2, 32'h40},
            '{32'h0, 32'h0, 2, 32'h0}, '{32'h0, 32'h0, 3, 32'h1e}};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(tsf_pkg::OFF_STATUS, 32'h0);
        rdchk(tsf_pkg::OFF_IRQ_MASK, 32'h0);
        rdchk(tsf_pkg::OFF_EVGEN, 32'h0);
        rdchk(8'h44, 32'h0);
        $display("reset values done");
        foreach (rows[i]) begin
            bus(1'b1, tsf_pkg::OFF_CONTROL, rows[i].ctrl);
            bus(1'b1, tsf_pkg::OFF_SLAVE, rows[i].slave);
            bus(1'b1, tsf_pkg::OFF_STATUS, 32'h0);
            case (rows[i].act)
                0: begin
                    counter_wrap <= 1'b1;
                    @(posedge clk);
                    counter_wrap <= 1'b0;
                end
                1: bus(1'b1, tsf_pkg::OFF_EVGEN, 32'h1);
                2: begin
                    toggle(1'b1, 1'b1);
                    toggle(1'b1, 1'b0);
                end
                default: bus(1'b1, tsf_pkg::OFF_EVGEN, 32'h1e);
            endcase
            rdchk(tsf_pkg::OFF_STATUS, rows[i].exp);
            $display("row %0d done", i);
        end
        bus(1'b1, tsf_pkg::OFF_STATUS, 32'hffff_fffd);
        rdchk(tsf_pkg::OFF_STATUS, 32'h1c);
        bus(1'b1, tsf_pkg::OFF_EVGEN, 32'h1e);
        rdchk(tsf_pkg::OFF_STATUS, 32'h1e);
        bus(1'b1, tsf_pkg::OFF_IRQ_MASK, 32'h4);
        #1 chk_bit(irq, 1'b1);
        bus(1'b1, tsf_pkg::OFF_IRQ_MASK, 32'h0);
        #1 chk_bit(irq, 1'b0);
        bus(1'b1, tsf_pkg::OFF_STATUS, 32'h0);
        rdchk(tsf_pkg::OFF_STATUS, 32'h0);
        $display("clear and interrupt done");
        bus(1'b1, tsf_pkg::OFF_CH_VALUE0 + 8'h04, 32'h5);
        for (int k = 0; k < 5; k++) begin
            center_align_select <= (k < 3) ? ((k == 0) ? tsf_pkg::ALIGN_EDGE : tsf_pkg::ALIGN_DOWN)
                                           : ((k == 3) ? tsf_pkg::ALIGN_UP : tsf_pkg::ALIGN_BOTH);
            count_down <= (k == 2 || k == 4);
            counter_value <= 16'h4;
            @(posedge clk);
            counter_value <= 16'h5;
            repeat (2) @(posedge clk);
            rdchk(tsf_pkg::OFF_STATUS, (k == 1) ? 32'h0 : 32'h4);
            bus(1'b1, tsf_pkg::OFF_STATUS, 32'h0);
        end
        $display("compare done");
        bus(1'b1, tsf_pkg::OFF_CH_CFG, 32'h1);
        counter_value <= 16'h1234;
        toggle(1'b0, 1'b1);
        rdchk(tsf_pkg::OFF_STATUS, 32'h2);
        rdchk(tsf_pkg::OFF_CH_VALUE0, 32'h1234);
        rdchk(tsf_pkg::OFF_STATUS, 32'h0);
        toggle(1'b0, 1'b0);
        toggle(1'b0, 1'b1);
        toggle(1'b0, 1'b0);
        counter_value <= 16'h0777;
        toggle(1'b0, 1'b1);
        rdchk(tsf_pkg::OFF_STATUS, 32'h202);
        rdchk(tsf_pkg::OFF_CH_VALUE0, 32'h0777);
        bus(1'b1, tsf_pkg::OFF_CH_CFG, 32'h11);
        bus(1'b1, tsf_pkg::OFF_STATUS, 32'h0);
        toggle(1'b0, 1'b0);
        rdchk(tsf_pkg::OFF_STATUS, 32'h2);
        $display("capture done");
        fork
            bus(1'b1, tsf_pkg::OFF_STATUS, 32'h0);
            begin
                @(posedge clk);
                counter_wrap <= 1'b1;
                repeat (2) @(posedge clk);
                counter_wrap <= 1'b0;
            end
        join
        rdchk(tsf_pkg::OFF_STATUS, 32'h1);
        $display("set over clear done");
        bus(1'b1, tsf_pkg::OFF_SLAVE, {30'h0, tsf_pkg::SLAVE_GATED});
        bus(1'b1, tsf_pkg::OFF_STATUS, 32'h0);
        toggle(1'b1, 1'b1);
        #1 chk_bit(gate_open, 1'b1);
        rdchk(tsf_pkg::OFF_STATUS, 32'h40);
        bus(1'b1, tsf_pkg::OFF_STATUS, 32'h0);
        repeat (8) @(posedge clk);
        rdchk(tsf_pkg::OFF_STATUS, 32'h0);
        toggle(1'b1, 1'b0);
        rdchk(tsf_pkg::OFF_STATUS, 32'h40);
        $display("gated mode done");
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(tsf_pkg::OFF_STATUS, 32'h0);
        rdchk(tsf_pkg::OFF_SLAVE, 32'h0);
        $display("second reset done");
        complete_run();
    end
endmodule
bind tsf_status_flags tsf_status_flags_properties #(.CHANNELS(CHANNELS), .CNT_WIDTH(CNT_WIDTH))
    u_props (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .counter_value(counter_value), .counter_wrap(counter_wrap), .count_down(count_down),
    .center_align_select(center_align_select), .slave_trigger_input(slave_trigger_input),
    .ch_input_signal(ch_input_signal), .counter_reinit(counter_reinit),
    .gate_open(gate_open), .irq(irq));
`default_nettype wire
